// *** dv/gpef_pad_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// board side of one port: wire level from pad drive and far end
module gpef_pad_model #(
	parameter int W = 8
) (
	input wire logic [W-1:0] pad_o_i,
	input wire logic [W-1:0] pad_oe_n_i,
	input wire logic [W-1:0] far_i,
	output logic [W-1:0] wire_o
);
	// undriven bits show the far end, never the last pad value
	assign wire_o = (~pad_oe_n_i & pad_o_i) | (pad_oe_n_i & far_i);
endmodule : gpef_pad_model
`default_nettype wire

// *** dv/gpef_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// port level checks
module gpef_sva (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic s_axi_bvalid_o,
	input wire logic [gpef_pkg::PE_W-1:0] pe_i,
	input wire logic [gpef_pkg::PE_W-1:0] pe_o,
	input wire logic [gpef_pkg::PE_W-1:0] pe_oe_n_o,
	input wire logic [gpef_pkg::PF_W-1:0] pf_o,
	input wire logic [gpef_pkg::PF_W-1:0] pf_oe_n_o,
	input wire logic spi_sck_out_i,
	input wire logic spi_ss_n_in_o,
	input wire logic sci_txd_i,
	input wire logic [gpef_pkg::TA_CH-1:0] tim_a_out_i,
	input wire logic [gpef_pkg::TA_CH-1:0] tim_a_drive_i,
	input wire logic [gpef_pkg::TB_CH-1:0] tim_b_drive_i,
	input wire gpef_pkg::gpef_ctrl_t periph_ctrl_o,
	input wire gpef_pkg::gpef_els_t timer_sel_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	wire logic spi_on = periph_ctrl_o.spi_enable_bit;
	wire logic spi_mst = spi_on && periph_ctrl_o.spi_master_select;
	wire logic spi_slv = spi_on && !periph_ctrl_o.spi_master_select;
	wire logic sci_on = periph_ctrl_o.sci_enable_bit;
	chk_dir_cleared: assert property ($rose(resetn_i) |-> &pe_oe_n_o && &pf_oe_n_o)
		else $error("pads driving right after reset");
	chk_txd_drive: assert property (
		$past(sci_on) |-> !pe_oe_n_o[0] && pe_o[0] == $past(sci_txd_i))
		else $error("transmit pin not carrying sci data");
	chk_rxd_input: assert property ($past(sci_on) |-> pe_oe_n_o[1])
		else $error("receive pin driven while sci on");
	chk_spi_slave: assert property (
		$past(spi_slv) |-> pe_oe_n_o[7:4] == 4'hD)
		else $error("slave spi pin directions wrong");
	chk_sck_master: assert property (
		$past(spi_mst) |-> !pe_oe_n_o[7] && pe_o[7] == $past(spi_sck_out_i))
		else $error("master clock pin not driven from spi");
	chk_ss_sync: assert property ($past(resetn_i, 2) |-> spi_ss_n_in_o == $past(pe_i[4], 2))
		else $error("slave select input not following pin");
	chk_ta_e2: assert property (
		$past(timer_sel_o.ta_els[0] != 2'h0) |-> pe_oe_n_o[2] == !$past(tim_a_drive_i[0]))
		else $error("timer pin direction not from timer");
	chk_ta_f0: assert property (
		$past(timer_sel_o.ta_els[2] != 2'h0) && $past(tim_a_drive_i[2])
		|-> !pf_oe_n_o[0] && pf_o[0] == $past(tim_a_out_i[2]))
		else $error("timer output not on its pin");
	chk_tb_f4: assert property (
		$past(timer_sel_o.tb_els[0] != 2'h0) |-> pf_oe_n_o[4] == !$past(tim_b_drive_i[0]))
		else $error("second timer pin direction wrong");
	chk_wr_answer: assert property (
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
		|=> !s_axi_bvalid_o ##1 s_axi_bvalid_o)
		else $error("write response timing wrong");
	cover property ($rose(sci_on));
	cover property ($rose(spi_mst));
	cover property ($rose(timer_sel_o.tb_els[0] != 2'h0));
endmodule : gpef_sva
bind gpef_top gpef_sva i_sva (
	.clk_i(clk_i), .resetn_i(resetn_i),
	.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bvalid_o(s_axi_bvalid_o), .pe_i(pe_i), .pe_o(pe_o), .pe_oe_n_o(pe_oe_n_o),
	.pf_o(pf_o), .pf_oe_n_o(pf_oe_n_o), .spi_sck_out_i(spi_sck_out_i),
	.spi_ss_n_in_o(spi_ss_n_in_o), .sci_txd_i(sci_txd_i), .tim_a_out_i(tim_a_out_i),
	.tim_a_drive_i(tim_a_drive_i), .tim_b_drive_i(tim_b_drive_i),
	.periph_ctrl_o(periph_ctrl_o), .timer_sel_o(timer_sel_o)
);
`default_nettype wire

// *** dv/gpef_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module gpef_top_tb;
	// =====================================================
	// stimulus and observed nets
	localparam logic [1:0] OK = gpef_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = gpef_pkg::RESP_SLVERR;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [7:0] aw_a = 8'h00;
	logic [7:0] ar_a = 8'h00;
	logic [31:0] w_d = 32'h0;
	logic aw_v = 1'b0;
	logic w_v = 1'b0;
	logic ar_v = 1'b0;
	logic aw_rdy, w_rdy, b_v, ar_rdy, r_v;
	logic [1:0] b_resp, r_resp;
	logic [31:0] r_d;
	logic [7:0] pe_in, pe_out, pe_oen;
	logic [6:0] pf_in, pf_out, pf_oen;
	logic [7:0] pe_far = 8'h00;
	logic [6:0] pf_far = 7'h00;
	logic [2:0] spi_out = 3'h0;
	logic sci_tx = 1'b0;
	logic [5:0] ta_out = 6'h00;
	logic [5:0] ta_drv = 6'h00;
	logic [1:0] tb_out = 2'h0;
	logic [1:0] tb_drv = 2'h0;
	logic [3:0] spi_in;
	logic sci_rx;
	logic [5:0] ta_in;
	logic [1:0] tb_in;
	gpef_pkg::gpef_ctrl_t ctrl;
	gpef_pkg::gpef_els_t sel;
	int n_mismatch = 0;
	int total_checks = 0;
	gpef_top i_dut (
		.clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v),
		.s_axi_awready_o(aw_rdy), .s_axi_wdata_i(w_d), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(w_v),
		.s_axi_wready_o(w_rdy), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_v),
		.s_axi_bready_i(1'b1), .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v),
		.s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_resp),
		.s_axi_rvalid_o(r_v), .s_axi_rready_i(1'b1), .pe_i(pe_in), .pe_o(pe_out),
		.pe_oe_n_o(pe_oen), .pf_i(pf_in), .pf_o(pf_out), .pf_oe_n_o(pf_oen),
		.spi_sck_out_i(spi_out[2]), .spi_mosi_out_i(spi_out[1]), .spi_miso_out_i(spi_out[0]),
		.spi_sck_in_o(spi_in[3]), .spi_mosi_in_o(spi_in[2]), .spi_miso_in_o(spi_in[1]),
		.spi_ss_n_in_o(spi_in[0]), .sci_txd_i(sci_tx), .sci_rxd_o(sci_rx),
		.tim_a_out_i(ta_out), .tim_a_drive_i(ta_drv), .tim_a_in_o(ta_in), .tim_b_out_i(tb_out),
		.tim_b_drive_i(tb_drv), .tim_b_in_o(tb_in), .periph_ctrl_o(ctrl), .timer_sel_o(sel)
	);
	gpef_pad_model #(.W(8)) i_pad_e (.pad_o_i(pe_out), .pad_oe_n_i(pe_oen), .far_i(pe_far),
		.wire_o(pe_in));
	gpef_pad_model #(.W(7)) i_pad_f (.pad_o_i(pf_out), .pad_oe_n_i(pf_oen), .far_i(pf_far),
		.wire_o(pf_in));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// =====================================================
	// shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic ta;
		logic tw;
		n = 0;
		ta = 1'b0;
		tw = 1'b0;
		aw_a <= a;
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			if (aw_rdy) ta = 1'b1;
			if (w_rdy) tw = 1'b1;
			if (ta) aw_v <= 1'b0;
			if (tw) w_v <= 1'b0;
		end while (!(ta && tw) && n < 50);
		do begin
			@(posedge clk_i);
			n++;
		end while (!b_v && n < 50);
		chk(b_v, 1'b1);
		chk(b_resp, er);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		ar_a <= a;
		ar_v <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (!ar_rdy && n < 50);
		ar_v <= 1'b0;
		do begin
			@(posedge clk_i);
			n++;
		end while (!r_v && n < 50);
		chk(r_v, 1'b1);
		chk(r_resp, er);
		chk(r_d, ed);
	endtask : rd
	// pad takes one edge, pin sync two more
	task automatic settle;
		repeat (3) @(posedge clk_i);
	endtask : settle
	task automatic do_reset;
		resetn_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
	endtask : do_reset
	// =====================================================
	// scenarios
	task automatic t_port_e;
		chk(pe_oen, 8'hFF);
		chk(pf_oen, 7'h7F);
		pe_far <= 8'hA5;
		wr(gpef_pkg::ADDR_PE_DATA, 32'h3C, OK);
		settle;
		rd(gpef_pkg::ADDR_PE_DATA, 32'hA5, OK);
		wr(gpef_pkg::ADDR_PE_DIR, 32'h0F, OK);
		settle;
		chk(pe_oen, 8'hF0);
		chk(pe_out[3:0], 4'hC);
		rd(gpef_pkg::ADDR_PE_DATA, 32'hAC, OK);
	endtask : t_port_e
	task automatic t_port_f;
		pf_far <= 7'h2A;
		wr(gpef_pkg::ADDR_PF_DATA, 32'hFF, OK);
		wr(gpef_pkg::ADDR_PF_DIR, 32'hF0, OK);
		settle;
		rd(gpef_pkg::ADDR_PF_DIR, 32'h70, OK);
		chk(pf_oen, 7'h0F);
		rd(gpef_pkg::ADDR_PF_DATA, 32'h7A, OK);
	endtask : t_port_f
	task automatic t_reset_keep;
		wr(gpef_pkg::ADDR_PE_DATA, 32'h5A, OK);
		wr(gpef_pkg::ADDR_PE_DIR, 32'hFF, OK);
		do_reset;
		rd(gpef_pkg::ADDR_PE_DIR, 32'h0, OK);
		rd(gpef_pkg::ADDR_PF_DIR, 32'h0, OK);
		wr(gpef_pkg::ADDR_PE_DIR, 32'hFF, OK);
		wr(gpef_pkg::ADDR_PF_DIR, 32'h7F, OK);
		rd(gpef_pkg::ADDR_PE_DATA, 32'h5A, OK);
		rd(gpef_pkg::ADDR_PF_DATA, 32'h7F, OK);
	endtask : t_reset_keep
	task automatic t_periph;
		logic [3:0] cv [5];
		logic [7:0] ev [5];
		logic [7:0] ov [5];
		logic [4:0] iv [5];
		cv = '{4'h8, 4'h1, 4'h3, 4'h7, 4'h0};
		ev = '{8'h02, 8'hD0, 8'h20, 8'h30, 8'h00};
		// pad drive values and synced spi/sci inputs per mode
		ov = '{8'h59, 8'h2A, 8'hDA, 8'hCA, 8'h5A};
		iv = '{5'h0A, 5'h15, 5'h1F, 5'h1D, 5'h0B};
		sci_tx <= 1'b1;
		spi_out <= 3'h7;
		for (int i = 0; i < 5; i++) begin
			wr(gpef_pkg::ADDR_PERIPH_CTRL, {28'h0, cv[i]}, OK);
			settle;
			chk(pe_oen, ev[i]);
			chk(ctrl, cv[i]);
			chk(pe_out, ov[i]);
			chk({spi_in, sci_rx}, iv[i]);
			rd(gpef_pkg::ADDR_PE_DATA, 32'h5A, OK);
		end
	endtask : t_periph
	task automatic t_timer;
		pf_far <= 7'h00;
		ta_out <= 6'h3F;
		ta_drv <= 6'h2D;
		tb_out <= 2'h3;
		tb_drv <= 2'h1;
		wr(gpef_pkg::ADDR_PE_DIR, 32'h00, OK);
		wr(gpef_pkg::ADDR_TIMER_SEL, 32'h5555, OK);
		settle;
		chk(sel, 16'h5555);
		chk(pe_oen, 8'hFB);
		chk(pf_oen, 7'h24);
		chk(pf_out, 7'h5B);
		rd(gpef_pkg::ADDR_PF_DATA, 32'h7F, OK);
		wr(gpef_pkg::ADDR_PF_DIR, 32'h00, OK);
		settle;
		rd(gpef_pkg::ADDR_PF_DATA, 32'h1B, OK);
		chk(ta_in, 6'h2D);
		chk(tb_in, 2'h1);
	endtask : t_timer
	task automatic t_unmapped;
		rd(8'h08, 32'h0, ERR);
		wr(8'h21, 32'hFF, ERR);
		rd(8'h21, 32'h0, ERR);
	endtask : t_unmapped
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results
	initial begin
		#100us;
		n_mismatch++;
		results;
	end
	initial begin
		do_reset;
		t_port_e;
		t_port_f;
		t_reset_keep;
		t_periph;
		t_timer;
		t_unmapped;
		results;
	end
endmodule : gpef_top_tb
`default_nettype wire

// *** hw/gpef_pin_cell.sv ***
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// one pad: peripheral or gpio drive, registered
module gpef_pin_cell (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic claim_i,
	input wire logic periph_drive_i,
	input wire logic periph_val_i,
	input wire logic dir_i,
	input wire logic latch_i,
	output logic pin_o,
	output logic pin_oe_n_o
);
	logic out_ff;
	logic oe_n_ff;
	wire nxt_drive = claim_i ? periph_drive_i : dir_i;
	wire nxt_out = claim_i ? periph_val_i : (dir_i & latch_i);

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			out_ff <= 1'b0;
			oe_n_ff <= 1'b1;
		end else begin
			out_ff <= nxt_out & nxt_drive;
			oe_n_ff <= ~nxt_drive;
		end
	end

	assign pin_o = out_ff;
	assign pin_oe_n_o = oe_n_ff;
endmodule : gpef_pin_cell
`default_nettype wire

// *** hw/gpef_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// two-stage synchroniser for pin levels
module gpef_sync #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_ff <= '0;
			q_ff <= '0;
		end else begin
			meta_ff <= d_i;
			q_ff <= meta_ff;
		end
	end

	assign q_o = q_ff;
endmodule : gpef_sync
`default_nettype wire

// *** hw/gpef_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module gpef_top (
	input wire logic clk_i,
	input wire logic resetn_i,
	// axi4-lite slave
	input wire logic [gpef_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [gpef_pkg::DATA_W-1:0] s_axi_wdata_i,
	input wire logic [gpef_pkg::DATA_W/8-1:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [gpef_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [gpef_pkg::DATA_W-1:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// pads
	input wire logic [gpef_pkg::PE_W-1:0] pe_i,
	output logic [gpef_pkg::PE_W-1:0] pe_o,
	output logic [gpef_pkg::PE_W-1:0] pe_oe_n_o,
	input wire logic [gpef_pkg::PF_W-1:0] pf_i,
	output logic [gpef_pkg::PF_W-1:0] pf_o,
	output logic [gpef_pkg::PF_W-1:0] pf_oe_n_o,
	// spi peripheral
	input wire logic spi_sck_out_i,
	input wire logic spi_mosi_out_i,
	input wire logic spi_miso_out_i,
	output logic spi_sck_in_o,
	output logic spi_mosi_in_o,
	output logic spi_miso_in_o,
	output logic spi_ss_n_in_o,
	// sci peripheral
	input wire logic sci_txd_i,
	output logic sci_rxd_o,
	// timer peripherals
	input wire logic [gpef_pkg::TA_CH-1:0] tim_a_out_i,
	input wire logic [gpef_pkg::TA_CH-1:0] tim_a_drive_i,
	output logic [gpef_pkg::TA_CH-1:0] tim_a_in_o,
	input wire logic [gpef_pkg::TB_CH-1:0] tim_b_out_i,
	input wire logic [gpef_pkg::TB_CH-1:0] tim_b_drive_i,
	output logic [gpef_pkg::TB_CH-1:0] tim_b_in_o,
	// control view for the peripherals
	output gpef_pkg::gpef_ctrl_t periph_ctrl_o,
	output gpef_pkg::gpef_els_t timer_sel_o
);
	// =====================================================
	// registers
	logic [gpef_pkg::PE_W-1:0] pe_latch_ff;
	logic [gpef_pkg::PF_W-1:0] pf_latch_ff;
	logic [gpef_pkg::PE_W-1:0] pe_dir_ff;
	logic [gpef_pkg::PF_W-1:0] pf_dir_ff;
	gpef_pkg::gpef_ctrl_t ctrl_ff;
	gpef_pkg::gpef_els_t els_ff;

	logic aw_ready_ff;
	logic w_ready_ff;
	logic [gpef_pkg::ADDR_W-1:0] aw_addr_ff;
	logic [gpef_pkg::DATA_W-1:0] w_data_ff;
	logic [gpef_pkg::DATA_W/8-1:0] w_strb_ff;
	logic b_valid_ff;
	logic [1:0] b_resp_ff;
	logic ar_ready_ff;
	logic r_valid_ff;
	logic [1:0] r_resp_ff;
	logic [gpef_pkg::DATA_W-1:0] r_data_ff;

	// =====================================================
	// synchronised pin levels
	logic [gpef_pkg::PE_W-1:0] pe_sync;
	logic [gpef_pkg::PF_W-1:0] pf_sync;

	gpef_sync #(
		.W(gpef_pkg::PE_W)
	) u_pe_sync (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.d_i(pe_i),
		.q_o(pe_sync)
	);

	gpef_sync #(
		.W(gpef_pkg::PF_W)
	) u_pf_sync (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.d_i(pf_i),
		.q_o(pf_sync)
	);

	// =====================================================
	// axi write channel
	wire aw_take = s_axi_awvalid_i & aw_ready_ff;
	wire w_take = s_axi_wvalid_i & w_ready_ff;
	wire wr_fire = ~aw_ready_ff & ~w_ready_ff & ~b_valid_ff;
	wire b_done = b_valid_ff & s_axi_bready_i;

	wire wsel_pe_data = (aw_addr_ff == gpef_pkg::ADDR_PE_DATA);
	wire wsel_pf_data = (aw_addr_ff == gpef_pkg::ADDR_PF_DATA);
	wire wsel_pe_dir = (aw_addr_ff == gpef_pkg::ADDR_PE_DIR);
	wire wsel_pf_dir = (aw_addr_ff == gpef_pkg::ADDR_PF_DIR);
	wire wsel_ctrl = (aw_addr_ff == gpef_pkg::ADDR_PERIPH_CTRL);
	wire wsel_els = (aw_addr_ff == gpef_pkg::ADDR_TIMER_SEL);
	wire wsel_any = wsel_pe_data | wsel_pf_data | wsel_pe_dir | wsel_pf_dir | wsel_ctrl
		| wsel_els;
	wire wr_lo = wr_fire & w_strb_ff[0];
	wire wr_hi = wr_fire & w_strb_ff[1];
	wire [gpef_pkg::BYTE_W-1:0] wr_byte0 = w_data_ff[gpef_pkg::BYTE_W-1:0];
	wire [gpef_pkg::BYTE_W-1:0] wr_byte1 = w_data_ff[2*gpef_pkg::BYTE_W-1:gpef_pkg::BYTE_W];

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			aw_ready_ff <= 1'b1;
			w_ready_ff <= 1'b1;
			aw_addr_ff <= '0;
			w_data_ff <= '0;
			w_strb_ff <= '0;
		end else begin
			if (aw_take) begin
				aw_ready_ff <= 1'b0;
				aw_addr_ff <= s_axi_awaddr_i;
			end else if (b_done) begin
				aw_ready_ff <= 1'b1;
			end
			if (w_take) begin
				w_ready_ff <= 1'b0;
				w_data_ff <= s_axi_wdata_i;
				w_strb_ff <= s_axi_wstrb_i;
			end else if (b_done) begin
				w_ready_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			b_valid_ff <= 1'b0;
			b_resp_ff <= gpef_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			b_valid_ff <= 1'b1;
			b_resp_ff <= wsel_any ? gpef_pkg::RESP_OKAY : gpef_pkg::RESP_SLVERR;
		end else if (b_done) begin
			b_valid_ff <= 1'b0;
		end
	end

	// =====================================================
	// register writes
	// data latches carry no reset so their contents survive it
	always_ff @(posedge clk_i) begin
		if (wr_lo && wsel_pe_data) begin
			pe_latch_ff <= wr_byte0;
		end
		if (wr_lo && wsel_pf_data) begin
			pf_latch_ff <= wr_byte0[gpef_pkg::PF_W-1:0];
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pe_dir_ff <= gpef_pkg::PE_DIR_RST;
			pf_dir_ff <= gpef_pkg::PF_DIR_RST;
			ctrl_ff <= gpef_pkg::CTRL_RST;
		end else if (wr_lo) begin
			if (wsel_pe_dir) begin
				pe_dir_ff <= wr_byte0;
			end
			if (wsel_pf_dir) begin
				pf_dir_ff <= wr_byte0[gpef_pkg::PF_W-1:0];
			end
			if (wsel_ctrl) begin
				ctrl_ff <= wr_byte0[$bits(gpef_pkg::gpef_ctrl_t)-1:0];
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			els_ff <= gpef_pkg::ELS_RST;
		end else begin
			if (wr_lo && wsel_els) begin
				els_ff[gpef_pkg::BYTE_W-1:0] <= wr_byte0;
			end
			if (wr_hi && wsel_els) begin
				els_ff[2*gpef_pkg::BYTE_W-1:gpef_pkg::BYTE_W] <= wr_byte1;
			end
		end
	end

	// =====================================================
	// axi read channel
	wire ar_take = s_axi_arvalid_i & ar_ready_ff;
	wire r_done = r_valid_ff & s_axi_rready_i;

	wire rsel_pe_data = (s_axi_araddr_i == gpef_pkg::ADDR_PE_DATA);
	wire rsel_pf_data = (s_axi_araddr_i == gpef_pkg::ADDR_PF_DATA);
	wire rsel_pe_dir = (s_axi_araddr_i == gpef_pkg::ADDR_PE_DIR);
	wire rsel_pf_dir = (s_axi_araddr_i == gpef_pkg::ADDR_PF_DIR);
	wire rsel_ctrl = (s_axi_araddr_i == gpef_pkg::ADDR_PERIPH_CTRL);
	wire rsel_els = (s_axi_araddr_i == gpef_pkg::ADDR_TIMER_SEL);
	wire rsel_any = rsel_pe_data | rsel_pf_data | rsel_pe_dir | rsel_pf_dir | rsel_ctrl
		| rsel_els;

	// read source follows the direction bit even on claimed pins
	wire [gpef_pkg::PE_W-1:0] pe_view = (pe_dir_ff & pe_latch_ff) | (~pe_dir_ff & pe_sync);
	wire [gpef_pkg::PF_W-1:0] pf_view = (pf_dir_ff & pf_latch_ff) | (~pf_dir_ff & pf_sync);

	wire [gpef_pkg::DATA_W-1:0] rd_mux =
		({gpef_pkg::DATA_W{rsel_pe_data}} & gpef_pkg::DATA_W'(pe_view)) |
		({gpef_pkg::DATA_W{rsel_pf_data}} & gpef_pkg::DATA_W'(pf_view)) |
		({gpef_pkg::DATA_W{rsel_pe_dir}} & gpef_pkg::DATA_W'(pe_dir_ff)) |
		({gpef_pkg::DATA_W{rsel_pf_dir}} & gpef_pkg::DATA_W'(pf_dir_ff)) |
		({gpef_pkg::DATA_W{rsel_ctrl}} & gpef_pkg::DATA_W'(ctrl_ff)) |
		({gpef_pkg::DATA_W{rsel_els}} & gpef_pkg::DATA_W'(els_ff));

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ar_ready_ff <= 1'b1;
			r_valid_ff <= 1'b0;
			r_resp_ff <= gpef_pkg::RESP_OKAY;
			r_data_ff <= '0;
		end else if (ar_take) begin
			ar_ready_ff <= 1'b0;
			r_valid_ff <= 1'b1;
			r_resp_ff <= rsel_any ? gpef_pkg::RESP_OKAY : gpef_pkg::RESP_SLVERR;
			r_data_ff <= rd_mux;
		end else if (r_done) begin
			ar_ready_ff <= 1'b1;
			r_valid_ff <= 1'b0;
		end
	end

	// =====================================================
	// pin ownership
	wire spi_on = ctrl_ff.spi_enable_bit;
	wire spi_mst = ctrl_ff.spi_master_select;
	wire ss_free = ~spi_on | (spi_mst & ~ctrl_ff.mode_fault_enable);
	wire sci_on = ctrl_ff.sci_enable_bit;

	logic [gpef_pkg::TA_CH-1:0] ta_on;
	logic [gpef_pkg::TB_CH-1:0] tb_on;

	generate
		for (genvar c = 0; c < gpef_pkg::TA_CH; c++) begin : g_ta_on
			assign ta_on[c] = (els_ff.ta_els[c] != gpef_pkg::ELS_OFF);
		end
		for (genvar c = 0; c < gpef_pkg::TB_CH; c++) begin : g_tb_on
			assign tb_on[c] = (els_ff.tb_els[c] != gpef_pkg::ELS_OFF);
		end
	endgenerate

	logic [gpef_pkg::PE_W-1:0] pe_claim;
	logic [gpef_pkg::PE_W-1:0] pe_pdrv;
	logic [gpef_pkg::PE_W-1:0] pe_pval;
	logic [gpef_pkg::PF_W-1:0] pf_claim;
	logic [gpef_pkg::PF_W-1:0] pf_pdrv;
	logic [gpef_pkg::PF_W-1:0] pf_pval;

	assign pe_claim[gpef_pkg::PE_SCK] = spi_on;
	assign pe_pdrv[gpef_pkg::PE_SCK] = spi_mst;
	assign pe_pval[gpef_pkg::PE_SCK] = spi_sck_out_i;
	assign pe_claim[gpef_pkg::PE_MOSI] = spi_on;
	assign pe_pdrv[gpef_pkg::PE_MOSI] = spi_mst;
	assign pe_pval[gpef_pkg::PE_MOSI] = spi_mosi_out_i;
	assign pe_claim[gpef_pkg::PE_MISO] = spi_on;
	assign pe_pdrv[gpef_pkg::PE_MISO] = ~spi_mst;
	assign pe_pval[gpef_pkg::PE_MISO] = spi_miso_out_i;
	// slave select is input only once claimed, direction bit unused
	assign pe_claim[gpef_pkg::PE_SS] = ~ss_free;
	assign pe_pdrv[gpef_pkg::PE_SS] = 1'b0;
	assign pe_pval[gpef_pkg::PE_SS] = 1'b0;
	assign pe_claim[gpef_pkg::PE_RXD] = sci_on;
	assign pe_pdrv[gpef_pkg::PE_RXD] = 1'b0;
	assign pe_pval[gpef_pkg::PE_RXD] = 1'b0;
	assign pe_claim[gpef_pkg::PE_TXD] = sci_on;
	assign pe_pdrv[gpef_pkg::PE_TXD] = 1'b1;
	assign pe_pval[gpef_pkg::PE_TXD] = sci_txd_i;

	generate
		for (genvar c = 0; c < gpef_pkg::TA_PE_CH; c++) begin : g_pe_tim
			assign pe_claim[gpef_pkg::PE_TA0+c] = ta_on[c];
			assign pe_pdrv[gpef_pkg::PE_TA0+c] = tim_a_drive_i[c];
			assign pe_pval[gpef_pkg::PE_TA0+c] = tim_a_out_i[c];
		end
		for (genvar c = gpef_pkg::TA_PE_CH; c < gpef_pkg::TA_CH; c++) begin : g_pf_ta
			assign pf_claim[gpef_pkg::PF_TA_LO+c-gpef_pkg::TA_PE_CH] = ta_on[c];
			assign pf_pdrv[gpef_pkg::PF_TA_LO+c-gpef_pkg::TA_PE_CH] = tim_a_drive_i[c];
			assign pf_pval[gpef_pkg::PF_TA_LO+c-gpef_pkg::TA_PE_CH] = tim_a_out_i[c];
		end
		for (genvar c = 0; c < gpef_pkg::TB_CH; c++) begin : g_pf_tb
			assign pf_claim[gpef_pkg::PF_TB_LO+c] = tb_on[c];
			assign pf_pdrv[gpef_pkg::PF_TB_LO+c] = tim_b_drive_i[c];
			assign pf_pval[gpef_pkg::PF_TB_LO+c] = tim_b_out_i[c];
		end
	endgenerate

	assign pf_claim[gpef_pkg::PF_PLAIN] = 1'b0;
	assign pf_pdrv[gpef_pkg::PF_PLAIN] = 1'b0;
	assign pf_pval[gpef_pkg::PF_PLAIN] = 1'b0;

	// =====================================================
	// pads: claimed pins follow the peripheral, others the direction bit
	generate
		for (genvar b = 0; b < gpef_pkg::PE_W; b++) begin : g_pe_pad
			gpef_pin_cell u_cell (
				.clk_i(clk_i),
				.resetn_i(resetn_i),
				.claim_i(pe_claim[b]),
				.periph_drive_i(pe_pdrv[b]),
				.periph_val_i(pe_pval[b]),
				.dir_i(pe_dir_ff[b]),
				.latch_i(pe_latch_ff[b]),
				.pin_o(pe_o[b]),
				.pin_oe_n_o(pe_oe_n_o[b])
			);
		end
		for (genvar b = 0; b < gpef_pkg::PF_W; b++) begin : g_pf_pad
			gpef_pin_cell u_cell (
				.clk_i(clk_i),
				.resetn_i(resetn_i),
				.claim_i(pf_claim[b]),
				.periph_drive_i(pf_pdrv[b]),
				.periph_val_i(pf_pval[b]),
				.dir_i(pf_dir_ff[b]),
				.latch_i(pf_latch_ff[b]),
				.pin_o(pf_o[b]),
				.pin_oe_n_o(pf_oe_n_o[b])
			);
		end
	endgenerate

	// =====================================================
	// outputs
	assign s_axi_awready_o = aw_ready_ff;
	assign s_axi_wready_o = w_ready_ff;
	assign s_axi_bvalid_o = b_valid_ff;
	assign s_axi_bresp_o = b_resp_ff;
	assign s_axi_arready_o = ar_ready_ff;
	assign s_axi_rvalid_o = r_valid_ff;
	assign s_axi_rresp_o = r_resp_ff;
	assign s_axi_rdata_o = r_data_ff;

	assign spi_sck_in_o = pe_sync[gpef_pkg::PE_SCK];
	assign spi_mosi_in_o = pe_sync[gpef_pkg::PE_MOSI];
	assign spi_miso_in_o = pe_sync[gpef_pkg::PE_MISO];
	assign spi_ss_n_in_o = pe_sync[gpef_pkg::PE_SS];
	assign sci_rxd_o = pe_sync[gpef_pkg::PE_RXD];
	assign tim_a_in_o = {pf_sync[gpef_pkg::PF_TB_LO-1:gpef_pkg::PF_TA_LO],
		pe_sync[gpef_pkg::PE_TA1:gpef_pkg::PE_TA0]};
	assign tim_b_in_o = pf_sync[gpef_pkg::PF_PLAIN-1:gpef_pkg::PF_TB_LO];
	assign periph_ctrl_o = ctrl_ff;
	assign timer_sel_o = els_ff;
endmodule : gpef_top
`default_nettype wire

// *** shared/gpef_pkg.sv ***
`default_nettype none
// =====================================================
// register map, field layout and bus codes
package gpef_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int PE_W = 8;
	localparam int PF_W = 7;
	localparam int IDX_PE_DATA = 'h08;
	localparam int IDX_PF_DATA = 'h09;
	localparam int IDX_PE_DIR = 'h0C;
	localparam int IDX_PF_DIR = 'h0D;
	localparam int IDX_PERIPH_CTRL = 'h10;
	localparam int IDX_TIMER_SEL = 'h11;
	localparam logic [ADDR_W-1:0] ADDR_PE_DATA = ADDR_W'(IDX_PE_DATA * 4);
	localparam logic [ADDR_W-1:0] ADDR_PF_DATA = ADDR_W'(IDX_PF_DATA * 4);
	localparam logic [ADDR_W-1:0] ADDR_PE_DIR = ADDR_W'(IDX_PE_DIR * 4);
	localparam logic [ADDR_W-1:0] ADDR_PF_DIR = ADDR_W'(IDX_PF_DIR * 4);
	localparam logic [ADDR_W-1:0] ADDR_PERIPH_CTRL = ADDR_W'(IDX_PERIPH_CTRL * 4);
	localparam logic [ADDR_W-1:0] ADDR_TIMER_SEL = ADDR_W'(IDX_TIMER_SEL * 4);
	localparam logic [PE_W-1:0] PE_DIR_RST = 8'h00;
	localparam logic [PF_W-1:0] PF_DIR_RST = 7'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int PE_SCK = 7;
	localparam int PE_MOSI = 6;
	localparam int PE_MISO = 5;
	localparam int PE_SS = 4;
	localparam int PE_TA1 = 3;
	localparam int PE_TA0 = 2;
	localparam int PE_RXD = 1;
	localparam int PE_TXD = 0;
	localparam int PF_TA_LO = 0;
	localparam int PF_TB_LO = 4;
	localparam int PF_PLAIN = 6;
	localparam int TA_CH = 6;
	localparam int TB_CH = 2;
	localparam int TA_PE_CH = 2;
	localparam int BYTE_W = 8;
	localparam logic [1:0] ELS_OFF = 2'h0;

	typedef struct packed {
		logic sci_enable_bit;
		logic mode_fault_enable;
		logic spi_master_select;
		logic spi_enable_bit;
	} gpef_ctrl_t;
	localparam gpef_ctrl_t CTRL_RST = 4'h0;

	typedef struct packed {
		logic [TB_CH-1:0][1:0] tb_els;
		logic [TA_CH-1:0][1:0] ta_els;
	} gpef_els_t;
	localparam gpef_els_t ELS_RST = 16'h0000;
endpackage : gpef_pkg
`default_nettype wire
